// ==== gth_pkg.sv ====
// Constants and state types for the bus handshake port
package gth_pkg;

    // ****************************************************************
    // Widths and depths
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int RX_W = 9;
    localparam int RX_DEPTH = 16;

    // ****************************************************************
    // Address groups (seven-bit command codes)
    // ****************************************************************
    localparam logic [6:0] LISTEN_BASE = 7'h20;
    localparam logic [6:0] TALK_BASE = 7'h40;
    localparam logic [6:0] SECOND_BASE = 7'h60;
    localparam logic [6:0] UNLISTEN_CODE = 7'h3F;
    localparam logic [6:0] UNTALK_CODE = 7'h5F;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // State machines
    // ****************************************************************
    typedef enum logic [1:0] {
        ACC_OFF,
        ACC_RDY,
        ACC_TAKE,
        ACC_DONE
    } gth_acc_t;

    typedef enum logic [1:0] {
        SRC_IDLE,
        SRC_SETL,
        SRC_VALID
    } gth_src_t;

endpackage

// ==== gth_port.sv ====
// Instrument-side bus port: receive FIFO, acceptor, source, addressing
`timescale 1ns/1ps

// ********************************************************************
// Receive FIFO
// ********************************************************************
module gth_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } gth_fifo_t;

    gth_fifo_t q;
    gth_fifo_t d;
    logic push;
    logic pop;

    assign in_ready = q.cnt != (AW + 1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = AW'(q.wr + 1'b1);
        end
        if (pop) begin
            d.rd = AW'(q.rd + 1'b1);
        end
        unique case ({push, pop})
            2'b10: d.cnt = (AW + 1)'(q.cnt + 1'b1);
            2'b01: d.cnt = (AW + 1)'(q.cnt - 1'b1);
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // gth_fifo

// ********************************************************************
// Overview of operation
// - Bus lines are low true, high released
// - Eight shared lines carry bytes and commands
// - One talker, many listeners, others unlisten
// - Primary address zero to thirty selects us; thirty-one only as talker
// - Listen byte is address OR 20h
// - Talk byte is address OR 40h
// - Secondary range 60h-7Fh is ignored
// - Talker sends response bytes, one per handshake
// - Attention marks command bytes, otherwise data
// - End-or-identify flags the final byte
// - Service request driven when user asks
// - Remote enable puts device in remote
// - Interface clear resets bus interface state
// - Only the source drives data valid
// - Acceptor holds not-ready until it can take
// - Acceptor holds not-accepted until byte latched
// - Source waits ready released, accepted asserted
// - Lines stable 100 ns before source evaluates
// - Valid low, then not-ready, then accepted release
// - Transfer paced by slowest acceptor, wired
// - Source drops valid and data after acceptance
// - Clear idles both talker and listener
// - Unlisten puts listener in idle
// ********************************************************************
module gth_port
    import gth_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] primary_addr,
    input wire logic [DATA_W-1:0] dio_in_n,
    output logic [DATA_W-1:0] dio_out_n,
    output logic dio_oe,
    input wire logic dav_in_n,
    output logic dav_out_n,
    output logic dav_oe,
    input wire logic nrfd_in_n,
    output logic nrfd_out_n,
    output logic nrfd_oe,
    input wire logic ndac_in_n,
    output logic ndac_out_n,
    output logic ndac_oe,
    input wire logic eoi_in_n,
    output logic eoi_out_n,
    output logic eoi_oe,
    output logic srq_out_n,
    output logic srq_oe,
    input wire logic atn_n,
    input wire logic ifc_n,
    input wire logic ren_n,
    input wire logic srq_req,
    input wire logic tx_valid,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_end,
    output logic tx_ready,
    output logic rx_valid,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_end,
    input wire logic rx_ready,
    output logic cmd_strobe,
    output logic [DATA_W-1:0] cmd_byte,
    output logic is_listener,
    output logic is_talker,
    output logic is_remote
);
    localparam int IN_W = ADDR_W + DATA_W + 7;

    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        gth_acc_t acc;
        gth_src_t src;
        logic [1:0] settle;
        logic listen;
        logic talk;
        logic remote;
        logic rx_push;
        logic [RX_W-1:0] rx_word;
        logic cmd_stb;
        logic [DATA_W-1:0] cmd;
        logic [DATA_W-1:0] dio_n;
        logic dio_oe;
        logic dav_oe;
        logic nrfd_oe;
        logic ndac_oe;
        logic eoi_oe;
        logic srq_oe;
        logic tx_full;
        logic [RX_W-1:0] tx_buf;
        logic tx_rdy;
    } gth_state_t;

    gth_state_t q;
    gth_state_t d;

    logic [ADDR_W-1:0] pa;
    logic [DATA_W-1:0] bus_byte;
    logic dav_t;
    logic nrfd_t;
    logic ndac_t;
    logic atn_t;
    logic ifc_t;
    logic ren_t;
    logic eoi_t;
    logic fifo_ready;
    logic [RX_W-1:0] fifo_out;
    logic involve;
    logic can_talk;

    // Own address match against one command group
    function automatic logic own_code(input logic [6:0] code,
                                      input logic [6:0] base,
                                      input logic [ADDR_W-1:0] addr);
        own_code = code == (base | {2'b00, addr});
    endfunction

    // ****************************************************************
    // Synchronised bus view, negative logic turned to true-high
    // ****************************************************************
    assign pa = q.s2[IN_W-1 -: ADDR_W];
    assign bus_byte = ~q.s2[DATA_W+6:7];
    assign dav_t = ~q.s2[6];
    assign nrfd_t = ~q.s2[5];
    assign ndac_t = ~q.s2[4];
    assign atn_t = ~q.s2[3];
    assign ifc_t = ~q.s2[2];
    assign ren_t = ~q.s2[1];
    assign eoi_t = ~q.s2[0];

    // A talker with attention released never listens to itself
    assign involve = atn_t || (q.listen && !q.talk);
    assign can_talk = q.talk && !atn_t;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.s1 = {primary_addr, dio_in_n, dav_in_n, nrfd_in_n, ndac_in_n,
                atn_n, ifc_n, ren_n, eoi_in_n};
        d.s2 = q.s1;
        d.rx_push = 1'b0;
        d.cmd_stb = 1'b0;
        d.remote = ren_t;
        d.srq_oe = srq_req;

        // Acceptor: lines are only pulled low, so the slowest one wins
        unique case (q.acc)
            ACC_OFF: begin
                d.nrfd_oe = 1'b0;
                d.ndac_oe = 1'b0;
                if (involve) begin
                    d.ndac_oe = 1'b1;
                    d.nrfd_oe = 1'b1;
                    d.acc = ACC_RDY;
                end
            end
            ACC_RDY: begin
                d.ndac_oe = 1'b1;
                // Data stalls here while the FIFO is full
                d.nrfd_oe = !(atn_t || fifo_ready);
                if (!involve) begin
                    d.acc = ACC_OFF;
                    d.nrfd_oe = 1'b0;
                    d.ndac_oe = 1'b0;
                end else if (dav_t && !q.nrfd_oe) begin
                    d.nrfd_oe = 1'b1;
                    d.acc = ACC_TAKE;
                    if (atn_t) begin
                        // Bit 8 is not part of the command code
                        if (bus_byte[6:5] == 2'b11) begin
                            d.acc = ACC_TAKE;
                        end else if (bus_byte[6:0] == UNLISTEN_CODE) begin
                            d.listen = 1'b0;
                        end else if (own_code(bus_byte[6:0], LISTEN_BASE,
                                              pa)) begin
                            d.listen = 1'b1;
                        end else if (own_code(bus_byte[6:0], TALK_BASE,
                                              pa)) begin
                            d.talk = 1'b1;
                        end else if (bus_byte[6:5] == 2'b10) begin
                            // Untalk or another device's talk address
                            d.talk = 1'b0;
                        end else if (bus_byte[6:5] == 2'b00) begin
                            d.cmd_stb = 1'b1;
                            d.cmd = bus_byte;
                        end
                    end else begin
                        d.rx_push = 1'b1;
                        d.rx_word = {eoi_t, bus_byte};
                    end
                end
            end
            ACC_TAKE: begin
                d.ndac_oe = 1'b0;
                d.acc = ACC_DONE;
            end
            ACC_DONE: begin
                if (!involve) begin
                    d.acc = ACC_OFF;
                    d.nrfd_oe = 1'b0;
                end else if (!dav_t) begin
                    d.ndac_oe = 1'b1;
                    d.acc = ACC_RDY;
                end
            end
        endcase

        // One-byte transmit holding register
        if (tx_valid && q.tx_rdy) begin
            d.tx_full = 1'b1;
            d.tx_buf = {tx_end, tx_data};
        end

        // Source
        unique case (q.src)
            SRC_IDLE: begin
                d.dav_oe = 1'b0;
                d.dio_oe = 1'b0;
                d.eoi_oe = 1'b0;
                if (can_talk && q.tx_full) begin
                    d.dio_n = ~q.tx_buf[DATA_W-1:0];
                    d.dio_oe = 1'b1;
                    d.eoi_oe = q.tx_buf[DATA_W];
                    d.settle = '0;
                    d.src = SRC_SETL;
                end
            end
            SRC_SETL: begin
                if (!can_talk) begin
                    d.dio_oe = 1'b0;
                    d.eoi_oe = 1'b0;
                    d.src = SRC_IDLE;
                end else if (nrfd_t || !ndac_t) begin
                    d.settle = '0;
                end else if (q.settle == 2'(SETTLE_CYC - 1)) begin
                    d.dav_oe = 1'b1;
                    d.src = SRC_VALID;
                end else begin
                    d.settle = 2'(q.settle + 1'b1);
                end
            end
            SRC_VALID: begin
                if (!can_talk) begin
                    d.dav_oe = 1'b0;
                    d.dio_oe = 1'b0;
                    d.eoi_oe = 1'b0;
                    d.src = SRC_IDLE;
                end else if (!ndac_t) begin
                    // All acceptors have the byte
                    d.dav_oe = 1'b0;
                    d.dio_oe = 1'b0;
                    d.eoi_oe = 1'b0;
                    d.tx_full = 1'b0;
                    d.src = SRC_IDLE;
                end
            end
            default: begin
                d.src = SRC_IDLE;
            end
        endcase

        // Interface clear overrides everything on the bus side except service request and remote enable
        if (ifc_t) begin
            d.listen = 1'b0;
            d.talk = 1'b0;
            d.acc = ACC_OFF;
            d.src = SRC_IDLE;
            d.dav_oe = 1'b0;
            d.dio_oe = 1'b0;
            d.eoi_oe = 1'b0;
            d.nrfd_oe = 1'b0;
            d.ndac_oe = 1'b0;
            d.rx_push = 1'b0;
            d.cmd_stb = 1'b0;
        end
        d.tx_rdy = !d.tx_full;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            // Line samples start released: no false clear or attention
            q <= '0;
            q.s1 <= '1;
            q.s2 <= '1;
        end else begin
            q <= d;
        end
    end

    gth_fifo #(
        .WIDTH(RX_W),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(q.rx_push),
        .in_data(q.rx_word),
        .in_ready(fifo_ready),
        .out_valid(rx_valid),
        .out_data(fifo_out),
        .out_ready(rx_ready)
    );

    // ****************************************************************
    // Outputs; control lines only ever pull low, data lines drive both levels
    // ****************************************************************
    assign dio_out_n = q.dio_n;
    assign dio_oe = q.dio_oe;
    assign dav_out_n = 1'b0;
    assign dav_oe = q.dav_oe;
    assign nrfd_out_n = 1'b0;
    assign nrfd_oe = q.nrfd_oe;
    assign ndac_out_n = 1'b0;
    assign ndac_oe = q.ndac_oe;
    assign eoi_out_n = 1'b0;
    assign eoi_oe = q.eoi_oe;
    assign srq_out_n = 1'b0;
    assign srq_oe = q.srq_oe;
    assign tx_ready = q.tx_rdy;
    assign rx_data = fifo_out[DATA_W-1:0];
    assign rx_end = fifo_out[DATA_W];
    assign cmd_strobe = q.cmd_stb;
    assign cmd_byte = q.cmd;
    assign is_listener = q.listen;
    assign is_talker = q.talk;
    assign is_remote = q.remote;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_take;
        q.acc == ACC_RDY && !q.nrfd_oe && dav_t && involve && !ifc_t;
    endsequence

    sequence s_cmd(logic [6:0] code);
        s_take ##0 atn_t && bus_byte[6:0] == code;
    endsequence

    a_dav_owner: assert property (
        q.dav_oe |-> q.talk && q.src == SRC_VALID)
        else $error("data valid driven outside source phase");

    a_ifc_idle: assert property (
        ifc_t |=> !q.listen && !q.talk && !q.dav_oe && !q.ndac_oe)
        else $error("interface clear left bus state active");

    a_unl_idle: assert property (
        s_cmd(UNLISTEN_CODE) |=> !q.listen)
        else $error("unlisten did not idle listener");

    a_lsn_addr: assert property (
        s_cmd(LISTEN_BASE | {2'b00, pa}) ##0 pa != 5'h1F |=> q.listen)
        else $error("own listen address not taken");

    a_tlk_addr: assert property (
        s_cmd(TALK_BASE | {2'b00, pa}) |=> q.talk)
        else $error("own talk address not taken");

    a_sec_ignored: assert property (
        s_take ##0 atn_t && bus_byte[6:5] == 2'b11
        |=> $stable(q.listen) && $stable(q.talk) && !q.cmd_stb)
        else $error("secondary address acted upon");

    a_take_order: assert property (
        s_take |=> q.nrfd_oe && q.ndac_oe ##1 !q.ndac_oe)
        else $error("acceptor release order broken");

    a_src_holdoff: assert property (
        q.src == SRC_SETL && (nrfd_t || !ndac_t) |=> !q.dav_oe)
        else $error("data valid before ready and accepted");

    a_settle_time: assert property (
        $rose(q.dav_oe) |-> $past(!nrfd_t && ndac_t, 1)
        && $past(!nrfd_t && ndac_t, 2) && $past(!nrfd_t && ndac_t, 3))
        else $error("source evaluated lines too early");

    a_src_release: assert property (
        q.src == SRC_VALID && !ndac_t |=> !q.dav_oe && !q.dio_oe)
        else $error("source kept data after acceptance");

    a_rx_stall: assert property (
        q.acc == ACC_RDY && involve && !ifc_t && !atn_t && !fifo_ready
        |=> q.nrfd_oe)
        else $error("ready released with full buffer");

    a_remote_mode: assert property (
        ren_t && srq_req |=> q.remote && q.srq_oe)
        else $error("remote or service request not followed");

endmodule // gth_port

// ==== gth_ctl_model.sv ====
// Bus controller model: source of commands and data, acceptor of replies
`timescale 1ns/1ps
module gth_ctl_model (
    input wire logic clk,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    input wire logic eoi_n,
    input wire logic [7:0] dio_n,
    output logic atn_n,
    output logic ifc_n,
    output logic ren_n,
    output logic dav_pull,
    output logic nrfd_pull,
    output logic ndac_pull,
    output logic eoi_pull,
    output logic [7:0] dio_pull
);
    // ****************************************************************
    // Line drive
    // ****************************************************************
    // Pulls only sink; a released line floats to its pull-up
    // Lone controller on a small bus
    initial begin
        {atn_n, ifc_n, ren_n} = 3'b111;
        {dav_pull, nrfd_pull, ndac_pull, eoi_pull} = 4'h0;
        dio_pull = 8'h00;
    end

    task automatic lines(input logic [2:0] v);
        @(negedge clk);
        {atn_n, ifc_n, ren_n} = v; // Only we drive these
    endtask

    // ****************************************************************
    // Source side
    // ****************************************************************
    task automatic send(input logic [7:0] b, input logic atn, input logic e);
        @(negedge clk);
        atn_n = ~atn;
        dio_pull = b;
        eoi_pull = e;
        repeat (4) @(negedge clk); // Settle after attention
        while (!(nrfd_n && !ndac_n)) @(negedge clk);
        dav_pull = 1'b1;
        while (!ndac_n) @(negedge clk); // Slowest decides
        dav_pull = 1'b0;
        dio_pull = 8'h00;
        eoi_pull = 1'b0;
    endtask

    // ****************************************************************
    // Acceptor side
    // ****************************************************************
    // Slow pacing stretches both halves, as a sluggish listener would
    task automatic take(input int slow, output logic [8:0] got);
        @(negedge clk);
        ndac_pull = 1'b1;
        nrfd_pull = 1'b1;
        repeat (slow + 1) @(negedge clk);
        nrfd_pull = 1'b0; // Ready
        while (dav_n) @(negedge clk);
        got = {~eoi_n, ~dio_n};
        nrfd_pull = 1'b1;
        repeat (slow) @(negedge clk);
        ndac_pull = 1'b0;
        while (!dav_n) @(negedge clk);
        ndac_pull = 1'b1;
    endtask

    task automatic idle();
        @(negedge clk);
        ndac_pull = 1'b0;
        nrfd_pull = 1'b0;
    endtask
endmodule // gth_ctl_model

// ==== tb_gpib_talk_listen_handshake.sv ====
// Self-checking bench for the instrument-side bus handshake port
`timescale 1ns/1ps
module tb_gpib_talk_listen_handshake;
    import gth_pkg::*;
    logic clk, reset, srq_req, tx_valid, tx_end, tx_ready, rx_ready;
    logic [4:0] pa;
    logic [7:0] tx_data, rx_data, cmd_byte, dio_out_n, dio_pull, dio_n;
    logic dio_oe, dav_out_n, dav_oe, nrfd_out_n, nrfd_oe, ndac_out_n;
    logic ndac_oe, eoi_out_n, eoi_oe, srq_out_n, srq_oe, rx_valid, rx_end;
    logic cmd_strobe, is_listener, is_talker, is_remote, atn_n, ifc_n;
    logic ren_n, dav_pull, nrfd_pull, ndac_pull, eoi_pull, dav_prev, done;
    logic dav_n, nrfd_n, ndac_n, eoi_n, srq_n, acc_seen;
    logic [8:0] got;
    int err_count, num_checks, cyc, rdy_cnt;
    logic [15:0] exp_cmd[$], exp_rx[$], exp_tx[$];

    // ****************************************************************
    // Wired bus
    // ****************************************************************
    assign dav_n = (dav_oe ? dav_out_n : 1'b1) & ~dav_pull;
    assign nrfd_n = (nrfd_oe ? nrfd_out_n : 1'b1) & ~nrfd_pull;
    assign ndac_n = (ndac_oe ? ndac_out_n : 1'b1) & ~ndac_pull;
    assign eoi_n = (eoi_oe ? eoi_out_n : 1'b1) & ~eoi_pull;
    assign srq_n = srq_oe ? srq_out_n : 1'b1;
    assign dio_n = (dio_oe ? dio_out_n : 8'hff) & ~dio_pull;

    gth_port u_dut (.clk, .reset, .primary_addr(pa), .dio_in_n(dio_n),
        .dio_out_n, .dio_oe, .dav_in_n(dav_n), .dav_out_n, .dav_oe,
        .nrfd_in_n(nrfd_n), .nrfd_out_n, .nrfd_oe, .ndac_in_n(ndac_n),
        .ndac_out_n, .ndac_oe, .eoi_in_n(eoi_n), .eoi_out_n, .eoi_oe,
        .srq_out_n, .srq_oe, .atn_n, .ifc_n, .ren_n, .srq_req, .tx_valid,
        .tx_data, .tx_end, .tx_ready, .rx_valid, .rx_data, .rx_end,
        .rx_ready, .cmd_strobe, .cmd_byte, .is_listener, .is_talker,
        .is_remote);

    gth_ctl_model u_ctl (.clk, .dav_n, .nrfd_n, .ndac_n, .eoi_n, .dio_n,
        .atn_n, .ifc_n, .ren_n, .dav_pull, .nrfd_pull, .ndac_pull,
        .eoi_pull, .dio_pull);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Monitors read pre-edge values, so they never race the design's update
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rdy_cnt <= (nrfd_n && !ndac_n) ? rdy_cnt + 1 : 0;
        dav_prev <= dav_oe;
        // Remembers that the acceptors released the accepted line
        acc_seen <= (dav_oe === 1'b1) ? (acc_seen | ndac_n) : 1'b0;
        if (cmd_strobe === 1'b1) begin
            check(cmd_byte, exp_cmd.size() ? exp_cmd.pop_front() : 16'hffff);
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            check({rx_end, rx_data}, exp_rx.size() ? exp_rx.pop_front() : 16'hffff);
        end
        if (dav_oe === 1'b1 && dav_prev !== 1'b1) begin
            check({is_talker, rdy_cnt >= 3}, 2'b11);
        end
        if (dav_oe === 1'b0 && dav_prev === 1'b1) begin
            check({acc_seen, dio_oe, eoi_oe}, 3'b100);
        end
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // ****************************************************************
    // Stimulus helpers
    // ****************************************************************
    task automatic cmd(input logic [7:0] b);
        u_ctl.send(b, 1'b1, 1'b0);
        u_ctl.lines(3'b111);
        repeat (4) @(negedge clk);
    endtask

    task automatic push_tx(input logic [7:0] b, input logic e);
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = b;
        tx_end = e;
        while (tx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hf0a2_4b07));
        {err_count, num_checks, cyc, rdy_cnt} = 0;
        {reset, srq_req, tx_valid, tx_end, rx_ready, done} = 6'b10_0000;
        tx_data = 8'h00;
        pa = 5'($urandom_range(0, 30));
        repeat (8) @(negedge clk);
        check({dio_oe, dav_oe, nrfd_oe, ndac_oe, tx_ready, is_talker}, 0);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        cmd(8'h20 | {3'b000, pa ^ 5'h01});
        check(is_listener, 0);
        cmd({1'b0, LISTEN_BASE} | {3'b000, pa});
        check(is_listener, 1);
        for (int i = 0; i < 4; i++) begin
            exp_cmd.push_back(16'($urandom_range(0, 31)));
            cmd(exp_cmd[$]);
        end
        cmd({1'b0, SECOND_BASE} | {3'b000, pa});
        cmd(8'h7f);
        check({is_listener, is_talker, 14'(exp_cmd.size())},
            16'h8000);
        // Sixteen bytes fill the buffer; the seventeenth must stall
        for (int i = 0; i < 17; i++) begin
            exp_rx.push_back(16'({i == 16, 8'($urandom)}));
        end
        for (int i = 0; i < 16; i++) begin
            u_ctl.send(exp_rx[i][7:0], 1'b0, exp_rx[i][8]);
        end
        fork
            begin
                u_ctl.send(exp_rx[16][7:0], 1'b0, 1'b1);
                done = 1'b1;
            end
        join_none
        repeat (20) @(negedge clk);
        check({nrfd_oe, done}, 2'b10);
        for (int i = 0; i < 600 && exp_rx.size() > 0; i++) begin
            @(negedge clk);
            rx_ready = 1'($urandom);
        end
        @(negedge clk);
        rx_ready = 1'b0;
        repeat (8) @(negedge clk);
        check({done, rx_valid, 14'(exp_rx.size())},
            16'h8000);
        cmd({1'b0, TALK_BASE} | {3'b000, pa});
        check({is_talker, is_listener}, 2'b11);
        fork
            for (int i = 0; i < 6; i++) begin
                exp_tx.push_back(16'({i == 5, 8'($urandom)}));
                push_tx(exp_tx[i][7:0], exp_tx[i][8]);
            end
            for (int i = 0; i < 6; i++) begin
                u_ctl.take($urandom_range(0, 6), got);
                check(got, exp_tx[i]);
            end
        join
        u_ctl.idle();
        cmd({1'b0, UNTALK_CODE});
        check(is_talker, 0);
        cmd({1'b0, UNLISTEN_CODE});
        check(is_listener, 0);
        u_ctl.lines(3'b110);
        repeat (4) @(negedge clk);
        check(is_remote, 1);
        u_ctl.lines(3'b111);
        srq_req = 1'b1;
        repeat (4) @(negedge clk);
        check({is_remote, srq_n}, 2'b00);
        srq_req = 1'b0;
        cmd({1'b0, LISTEN_BASE} | {3'b000, pa});
        cmd({1'b0, TALK_BASE} | {3'b000, pa});
        u_ctl.lines(3'b101);
        repeat (5) @(negedge clk);
        check({is_listener, is_talker, nrfd_oe, ndac_oe, dav_oe, srq_n}, 1);
        u_ctl.lines(3'b111);
        repeat (5) @(negedge clk);
        conclude();
    end
endmodule // tb_gpib_talk_listen_handshake
